// [core/core_status_option_regs.sv]
`timescale 1ns/1ps
`include "core_regs_consts.svh"

// Functional notes
// RULE1: flag-updating writes to the flag register keep alu zero, nibble and carry.
// RULE2: writes to watchdog-expiry and power-down bits are ignored.
// RULE3: file clear zeroes bank bits, sets zero, keeps other flags.
// RULE4: software should alter flags only by bit set/clear, swap, move.
// RULE5: subtraction adds two's complement; carry flags mean inverted borrow.
// RULE6: bit 7 picks indirect bank pair: 1 gives 100h-1FFh, 0 gives 00h-FFh.
// RULE7: bits 6-5 pick the direct bank 0 to 3.
// RULE8: watchdog-expiry set at power-up, kick, sleep; cleared on timeout.
// RULE9: power-down set at power-up and kick; cleared by sleep.
// RULE10: zero flag follows whether the alu result is zero.
// RULE11: nibble flag is carry out of bit 3 for add and subtract.
// RULE12: carry is msb carry for add/sub, shifted-out bit for rotates.
// RULE13: option bit 7 set disables all port b pull-ups.
// RULE14: option bit 6 selects rising or falling external interrupt edge.
// RULE15: option bit 5 selects timer pin or internal instruction clock.
// RULE16: option bit 4 selects falling or rising timer pin edge.
// RULE17: option bit 3 gives the prescaler to watchdog or timer zero.
// RULE18: rate n divides timer zero by 2^(n+1), watchdog by 2^n. The code gives tmr0_div_log2 the value n, and wdt_div_log2 n only while bit 3 is set, else 0.
// RULE19: software assigns prescaler to watchdog for undivided timer zero.
// RULE20: flag register is reachable at one location from every bank.
module core_status_option_regs
  import core_regs_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // core side
  input wire core_regs_pkg::core_req_t core_req,
  input wire core_regs_pkg::alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] ind_ptr,
  input wire logic [7:0] pullup_enable_reg,
  // outputs to the rest of the chip
  output logic [7:0] alu_result,
  output logic [8:0] direct_addr,
  output logic [8:0] indirect_addr,
  output logic [7:0] pull_up_en,
  output logic ext_int_edge_sel,
  output logic tmr0_src_sel,
  output logic tmr0_edge_sel,
  output logic prescale_assign,
  output logic [2:0] tmr0_div_log2,
  output logic [2:0] wdt_div_log2,
  output logic tmr0_prescaled
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] flags_reg, flags_next;
  logic [7:0] options_reg, options_next;
  logic [7:0] alu_result_reg;
  logic [7:0] pull_up_reg;
  option_t opt_reg;
  bus_state_t bus_reg, bus_next;
  logic [31:0] readdata_reg, readdata_next;
  logic [1:0] resp_reg, resp_next;
  alu_out_t alu;

  // fold a byte-enabled write into one 8-bit register
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd, input logic be0);
    merge_byte = be0 ? wd[7:0] : old;
  endfunction

  alu_flags u_alu (
    .a(alu_a),
    .b(alu_b),
    .op(alu_op),
    .carry_in(flags_reg[`BIT_CARRY]),
    .res(alu)
  );

  // ****************************************************************
  // avalon decode
  // ****************************************************************
  wire bus_take = (bus_reg == BUS_IDLE) && (read || write);
  wire hit_flags = (address == `OFS_FLAGS);
  wire hit_opts = (address == `OFS_OPTIONS);
  wire hit_cmd = (address == `OFS_CORE_CMD);
  wire hit_res = (address == `OFS_ALU_RES);
  wire mapped = hit_flags || hit_opts || hit_cmd || hit_res;
  wire sw_wr_flags = bus_take && write && hit_flags;
  wire sw_wr_opts = bus_take && write && hit_opts;
  wire sw_wr_cmd = bus_take && write && hit_cmd && byteenable[0];

  // one wait cycle then ack; waitrequest low in BUS_ACK
  assign waitrequest = (bus_reg != BUS_ACK);
  assign readdata = readdata_reg;
  assign response = resp_reg;

  // bus sequencing
  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      BUS_IDLE: bus_next = (read || write) ? BUS_ACK : BUS_IDLE;
      BUS_ACK: bus_next = BUS_DONE;
      BUS_DONE: bus_next = BUS_IDLE;
      default: bus_next = BUS_IDLE;
    endcase
  end

  // read mux, captured at the take edge so data is stable during ack
  always_comb begin
    readdata_next = readdata_reg;
    resp_next = resp_reg;
    if (bus_take) begin
      resp_next = mapped ? 2'b00 : 2'b10;
      if (!read) begin
        readdata_next = 32'h0;
      end else if (hit_flags) begin
        readdata_next = {24'h0, flags_reg};
      end else if (hit_opts) begin
        readdata_next = {24'h0, options_reg};
      end else if (hit_res) begin
        readdata_next = {21'h0, alu.carry, alu.nibble, alu.zero, alu.result} & `ALU_RES_MASK;
      end else begin
        readdata_next = 32'h0;
      end
    end
  end

  // ****************************************************************
  // flag register update
  // ****************************************************************
  // core write data: bus command word or the core's own request
  wire core_wr = core_req.wr_en || sw_wr_cmd;
  wire [7:0] core_wd = core_req.wr_en ? core_req.wr_data : writedata[7:0];
  wire [7:0] sw_flags = merge_byte(flags_reg, writedata, byteenable[0]);

  always_comb begin
    flags_next = flags_reg;
    // plain write from bus or core, hardware-only bits held back
    if (sw_wr_flags) begin
      flags_next = (sw_flags & ~`HW_ONLY_MASK) | (flags_reg & `HW_ONLY_MASK); // RULE2
    end
    if (core_wr) begin
      flags_next = (core_wd & ~`HW_ONLY_MASK) | (flags_reg & `HW_ONLY_MASK); // RULE2
    end
    // clear drops bank bits, sets zero, others unchanged
    if (core_req.file_clear) begin
      flags_next[`BIT_IND_BANK] = 1'b0; // RULE3
      flags_next[`BIT_DBANK_HI] = 1'b0; // RULE3
      flags_next[`BIT_DBANK_LO] = 1'b0; // RULE3
      flags_next[`BIT_ZERO] = 1'b1; // RULE3
      flags_next[`BIT_NIBBLE] = flags_reg[`BIT_NIBBLE];
      flags_next[`BIT_CARRY] = flags_reg[`BIT_CARRY];
    end
    // alu flags win over any written value
    if (core_req.flag_upd) begin
      flags_next[`BIT_ZERO] = alu.zero; // RULE1 RULE10
      if (alu_op == OP_ADD || alu_op == OP_SUB) begin
        flags_next[`BIT_NIBBLE] = alu.nibble; // RULE1 RULE11
      end else begin
        flags_next[`BIT_NIBBLE] = flags_reg[`BIT_NIBBLE]; // RULE1
      end
      if (alu_op == OP_ADD || alu_op == OP_SUB || alu_op == OP_ROT_L || alu_op == OP_ROT_R) begin
        flags_next[`BIT_CARRY] = alu.carry; // RULE1 RULE12
      end else begin
        flags_next[`BIT_CARRY] = flags_reg[`BIT_CARRY]; // RULE1
      end
    end
    // hardware events; kick wins over a simultaneous timeout
    if (core_req.wdt_timeout) begin
      flags_next[`BIT_WDT_EXP] = 1'b0; // RULE8
    end
    if (core_req.sleep) begin
      flags_next[`BIT_WDT_EXP] = 1'b1; // RULE8
      flags_next[`BIT_PWR_DN] = 1'b0; // RULE9
    end
    if (core_req.kick) begin
      flags_next[`BIT_WDT_EXP] = 1'b1; // RULE8
      flags_next[`BIT_PWR_DN] = 1'b1; // RULE9
    end
  end

  // options: plain read/write byte
  always_comb begin
    options_next = options_reg;
    if (sw_wr_opts) begin
      options_next = merge_byte(options_reg, writedata, byteenable[0]);
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // power-up leaves both reset-cause bits set
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg <= `FLAGS_RESET; // RULE8 RULE9
      options_reg <= `OPTIONS_RESET;
      bus_reg <= BUS_IDLE;
      readdata_reg <= 32'h0;
      resp_reg <= 2'b00;
    end else begin
      flags_reg <= flags_next;
      options_reg <= options_next;
      bus_reg <= bus_next;
      readdata_reg <= readdata_next;
      resp_reg <= resp_next;
    end
  end

  // registered outputs toward the chip
  always_ff @(posedge mclk) begin
    if (rst) begin
      alu_result_reg <= 8'h00;
      pull_up_reg <= 8'h00;
      opt_reg <= option_t'(`OPTIONS_RESET);
    end else begin
      alu_result_reg <= alu.result;
      pull_up_reg <= options_next[`BIT_PULL_OFF] ? 8'h00 : pullup_enable_reg; // RULE13
      opt_reg <= option_t'(options_next);
    end
  end

  // ****************************************************************
  // address formation and option decode
  // ****************************************************************
  // bank bits extend both addresses; flag register sits in every bank
  assign direct_addr = {flags_reg[`BIT_DBANK_HI], flags_reg[`BIT_DBANK_LO], file_addr}; // RULE7 RULE20
  assign indirect_addr = {flags_reg[`BIT_IND_BANK], ind_ptr}; // RULE6
  assign alu_result = alu_result_reg;
  assign pull_up_en = pull_up_reg; // RULE13
  assign ext_int_edge_sel = opt_reg.ext_int_edge_sel; // RULE14
  assign tmr0_src_sel = opt_reg.tmr0_src_sel; // RULE15
  assign tmr0_edge_sel = opt_reg.tmr0_edge_sel; // RULE16
  assign prescale_assign = opt_reg.prescale_assign; // RULE17
  // timer zero always gets the option rate; watchdog rate is zero unless it owns the prescaler
  assign wdt_div_log2 = opt_reg.prescale_assign ? opt_reg.prescale_rate : 3'h0; // RULE18
  assign tmr0_div_log2 = opt_reg.prescale_rate; // RULE18
  // undivided timer only while prescaler is lent to the watchdog
  assign tmr0_prescaled = ~opt_reg.prescale_assign; // RULE17 RULE19

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_clear_op;
    core_req.file_clear && !core_req.flag_upd;
  endsequence

  sequence s_clear_done;
    flags_reg[7:5] == 3'b000 && flags_reg[`BIT_ZERO];
  endsequence

  a_clear_sets_zero: assert property (@(posedge mclk) disable iff (rst) s_clear_op |=> s_clear_done) // RULE3
    else $error("file clear did not zero bank bits and set zero");

  a_hw_bits_locked: assert property (@(posedge mclk) disable iff (rst) // RULE2
    (!core_req.kick && !core_req.sleep && !core_req.wdt_timeout)
    |=> flags_reg[4:3] == $past(flags_reg[4:3]))
    else $error("reset-cause bits changed without a hardware event");

  a_alu_zero_wins: assert property (@(posedge mclk) disable iff (rst) // RULE1
    core_req.flag_upd |=> flags_reg[`BIT_ZERO] == $past(alu.zero))
    else $error("alu zero flag lost to written value");

  a_sleep_flags: assert property (@(posedge mclk) disable iff (rst) // RULE8
    core_req.sleep && !core_req.kick |=> flags_reg[4:3] == 2'b10)
    else $error("sleep did not set expiry and clear power-down");

  a_kick_flags: assert property (@(posedge mclk) disable iff (rst) // RULE9
    core_req.kick |=> flags_reg[4:3] == 2'b11)
    else $error("kick did not set both reset-cause bits");

  a_timeout_clears: assert property (@(posedge mclk) disable iff (rst) // RULE8
    core_req.wdt_timeout && !core_req.kick && !core_req.sleep |=> !flags_reg[`BIT_WDT_EXP])
    else $error("timeout did not clear expiry flag");

  a_sub_carry_ok: assert property (@(posedge mclk) disable iff (rst) // RULE5
    core_req.flag_upd && alu_op == OP_SUB |=> flags_reg[`BIT_CARRY] == ($past(alu_a) >= $past(alu_b)))
    else $error("subtract carry is not inverted borrow");

  a_add_nibble_ok: assert property (@(posedge mclk) disable iff (rst) // RULE11
    core_req.flag_upd && alu_op == OP_ADD
    |=> flags_reg[`BIT_NIBBLE] == (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}) > 5'h0f))
    else $error("nibble flag wrong after add");

  a_pullup_off: assert property (@(posedge mclk) disable iff (rst) // RULE13
    sw_wr_opts && byteenable[0] && writedata[`BIT_PULL_OFF] |=> pull_up_en == 8'h00)
    else $error("pull-ups enabled while disabled by option");

  a_bank_follow: assert property (@(posedge mclk) disable iff (rst) // RULE6 RULE7
    direct_addr[8:7] == flags_reg[6:5] && indirect_addr[8] == flags_reg[7])
    else $error("bank address bits do not follow flag register");

  a_bus_ack_once: assert property (@(posedge mclk) disable iff (rst)
    bus_take |=> !waitrequest ##1 waitrequest)
    else $error("bus ack not exactly one cycle after take");

  // a clear with no alu flag update or hardware event in the same cycle
  sequence s_clear_quiet;
    s_clear_op ##0 (!core_req.kick && !core_req.sleep && !core_req.wdt_timeout);
  endsequence

  a_clear_keeps: assert property (@(posedge mclk) disable iff (rst) // RULE3
    s_clear_quiet |=> flags_reg[4:3] == $past(flags_reg[4:3]) && flags_reg[1:0] == $past(flags_reg[1:0]))
    else $error("file clear disturbed reset-cause, nibble or carry bits");

  a_opt_follow: assert property (@(posedge mclk) disable iff (rst) // RULE14 RULE15 RULE16 RULE17
    {ext_int_edge_sel, tmr0_src_sel, tmr0_edge_sel, prescale_assign} == options_reg[6:3])
    else $error("option outputs do not follow option register");

  a_rate_split: assert property (@(posedge mclk) disable iff (rst) // RULE18
    tmr0_div_log2 == options_reg[2:0] && wdt_div_log2 == (options_reg[`BIT_PS_ASSIGN] ? options_reg[2:0] : 3'h0))
    else $error("prescale rate not split between timer and watchdog");

  a_timer_undivided: assert property (@(posedge mclk) disable iff (rst) // RULE17
    tmr0_prescaled != prescale_assign)
    else $error("timer prescale use disagrees with assignment");

  a_pullup_pass: assert property (@(posedge mclk) disable iff (rst) // RULE13
    !options_reg[`BIT_PULL_OFF] |-> pull_up_en == $past(pullup_enable_reg))
    else $error("enabled pull-ups do not follow per-pin enables");

  a_add_carry_ok: assert property (@(posedge mclk) disable iff (rst) // RULE12
    core_req.flag_upd && alu_op == OP_ADD |=> flags_reg[`BIT_CARRY] == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > 9'h0ff))
    else $error("carry wrong after add");

  a_sub_nibble_ok: assert property (@(posedge mclk) disable iff (rst) // RULE5 RULE11
    core_req.flag_upd && alu_op == OP_SUB |=> flags_reg[`BIT_NIBBLE] == ($past(alu_a[3:0]) >= $past(alu_b[3:0])))
    else $error("nibble flag is not inverted digit borrow");

  a_rotl_carry: assert property (@(posedge mclk) disable iff (rst) // RULE12
    core_req.flag_upd && alu_op == OP_ROT_L |=> flags_reg[`BIT_CARRY] == $past(alu_a[7]))
    else $error("rotate left did not move msb into carry");

  a_rotr_carry: assert property (@(posedge mclk) disable iff (rst) // RULE12
    core_req.flag_upd && alu_op == OP_ROT_R |=> flags_reg[`BIT_CARRY] == $past(alu_a[0]))
    else $error("rotate right did not move lsb into carry");

  a_logic_zero: assert property (@(posedge mclk) disable iff (rst) // RULE10
    core_req.flag_upd && alu_op == OP_LOGIC |=> flags_reg[`BIT_ZERO] == ($past(alu_a & alu_b) == 8'h00))
    else $error("zero flag wrong after logic result");

endmodule

// [core/core_regs_consts.svh]
`ifndef CORE_REGS_CONSTS_SVH
`define CORE_REGS_CONSTS_SVH

// ****************************************************************
// register map, byte addresses on the avalon slave
// ****************************************************************
`define OFS_FLAGS 4'h0
`define OFS_OPTIONS 4'h4
`define OFS_CORE_CMD 4'h8
`define OFS_ALU_RES 4'hc

// ****************************************************************
// flag register field positions
// ****************************************************************
`define BIT_IND_BANK 7
`define BIT_DBANK_HI 6
`define BIT_DBANK_LO 5
`define BIT_WDT_EXP 4
`define BIT_PWR_DN 3
`define BIT_ZERO 2
`define BIT_NIBBLE 1
`define BIT_CARRY 0

// ****************************************************************
// option register field positions
// ****************************************************************
`define BIT_PULL_OFF 7
`define BIT_INT_EDGE 6
`define BIT_T0_SRC 5
`define BIT_T0_EDGE 4
`define BIT_PS_ASSIGN 3

// ****************************************************************
// reset values and masks
// ****************************************************************
`define FLAGS_RESET 8'h18
`define OPTIONS_RESET 8'hff
`define ALU_FLAG_MASK 8'h07
`define HW_ONLY_MASK 8'h18
`define ALU_RES_MASK 32'h0000_07ff

`endif

// [core/core_regs_pkg.sv]
package core_regs_pkg;

  // alu operation codes issued by the core
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_LOGIC = 4'h3,
    OP_ROT_L = 4'h4,
    OP_ROT_R = 4'h5,
    OP_MOVE = 4'h6
  } alu_op_t;

  // one instruction's effect on the flag register
  typedef struct packed {
    logic wr_en;
    logic [7:0] wr_data;
    logic flag_upd;
    logic file_clear;
    logic kick;
    logic sleep;
    logic wdt_timeout;
  } core_req_t;

  // decoded option bits
  typedef struct packed {
    logic pull_up_off;
    logic ext_int_edge_sel;
    logic tmr0_src_sel;
    logic tmr0_edge_sel;
    logic prescale_assign;
    logic [2:0] prescale_rate;
  } option_t;

  // alu result bundle
  typedef struct packed {
    logic [7:0] result;
    logic zero;
    logic nibble;
    logic carry;
  } alu_out_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;

endpackage

// [core/alu_flags.sv]
`timescale 1ns/1ps
`include "core_regs_consts.svh"

module alu_flags
  import core_regs_pkg::*;
(
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire core_regs_pkg::alu_op_t op,
  input wire logic carry_in,
  // result
  output core_regs_pkg::alu_out_t res
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] b_eff;
  logic cin;

  // subtraction adds the two's complement, so carry means "no borrow"
  assign b_eff = (op == OP_SUB) ? ~b : b; // RULE5
  assign cin = (op == OP_SUB);
  assign sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin}; // RULE11

  // result and flag selection
  always_comb begin
    res = '0;
    res.carry = carry_in;
    res.nibble = 1'b0;
    case (op)
      OP_ADD, OP_SUB: begin
        res.result = sum[7:0];
        res.carry = sum[8]; // RULE12
        res.nibble = low_sum[4]; // RULE11
      end
      OP_ROT_L: begin
        res.result = {a[6:0], carry_in};
        res.carry = a[7]; // RULE12
      end
      OP_ROT_R: begin
        res.result = {carry_in, a[7:1]};
        res.carry = a[0]; // RULE12
      end
      OP_LOGIC: res.result = a & b;
      default: res.result = a;
    endcase
    res.zero = (res.result == 8'h00); // RULE10
  end

endmodule

// [dv/core_model.sv]
`timescale 1ns/1ps

// ****************************************
// instruction side of the core
// ****************************************
module core_model
  import core_regs_pkg::*;
(
  // clock
  input wire logic mclk,
  // one instruction's request and alu operands
  output core_regs_pkg::core_req_t core_req,
  output core_regs_pkg::alu_op_t alu_op,
  output logic [7:0] alu_a,
  output logic [7:0] alu_b
);
  initial begin
    core_req = '0;
    alu_op = OP_NONE;
    alu_a = 8'h00;
    alu_b = 8'h00;
  end

  // request lives one edge; operands stay so the registered result holds still
  task automatic issue(input core_req_t req, input alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    core_req <= req;
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    @(posedge mclk);
    core_req <= '0;
  endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "core_regs_consts.svh"

module testbench;
  import core_regs_pkg::*;
  typedef struct packed {logic [31:0] data; logic [1:0] resp;} exp_t;
  logic mclk, rst, read, write, waitrequest;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata;
  logic [1:0] response;
  core_req_t core_req, req;
  alu_op_t alu_op, op;
  logic [7:0] alu_a, alu_b, ind_ptr, pullup_enable_reg, alu_result, pull_up_en, flags, opts, a, b, res;
  logic [6:0] file_addr;
  logic [8:0] direct_addr, indirect_addr, s;
  logic ext_int_edge_sel, tmr0_src_sel, tmr0_edge_sel, prescale_assign, tmr0_prescaled, c, dc;
  logic [2:0] tmr0_div_log2, wdt_div_log2;
  exp_t exp_q[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  core_status_option_regs dut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .core_req(core_req), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
    .file_addr(file_addr), .ind_ptr(ind_ptr), .pullup_enable_reg(pullup_enable_reg),
    .alu_result(alu_result), .direct_addr(direct_addr), .indirect_addr(indirect_addr),
    .pull_up_en(pull_up_en), .ext_int_edge_sel(ext_int_edge_sel), .tmr0_src_sel(tmr0_src_sel),
    .tmr0_edge_sel(tmr0_edge_sel), .prescale_assign(prescale_assign), .tmr0_div_log2(tmr0_div_log2),
    .wdt_div_log2(wdt_div_log2), .tmr0_prescaled(tmr0_prescaled));
  core_model core (.mclk(mclk), .core_req(core_req), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b));

  // ****************************************
  // clock, watchdog on the run, verdict
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // far more than the whole sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_port(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_read(input exp_t e);
    samples_checked++;
    if ({readdata, response} !== e) begin
      n_errors++;
      $display("[ERR] readdata/response expected %h/%h seen %h/%h", e.data, e.resp, readdata, response);
    end
  endtask

  // read answers are judged at the ack edge against the oldest note
  always @(posedge mclk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      check_read((exp_q.size() > 0) ? exp_q.pop_front() : '1);
    end
  end

  // ****************************************
  // avalon master
  // ****************************************
  // request held until waitrequest is seen low; the bench timeout ends a hang
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] d, input logic [3:0] be);
    @(posedge mclk);
    address <= adr;
    writedata <= {24'h0, d};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({d, r});
    bus(1'b0, adr, 8'h00, 4'hf);
  endtask

  task automatic check_opts();
    @(negedge mclk);
    check_port("pull_up_en", opts[7] ? 8'h00 : pullup_enable_reg, pull_up_en);
    check_port("int_edge", opts[6], ext_int_edge_sel);
    check_port("tmr0_src", opts[5], tmr0_src_sel);
    check_port("tmr0_edge", opts[4], tmr0_edge_sel);
    check_port("assign", opts[3], prescale_assign);
    check_port("prescaled", !opts[3], tmr0_prescaled);
    check_port("tmr0_div", opts[2:0], tmr0_div_log2);
    check_port("wdt_div", opts[3] ? opts[2:0] : 3'h0, wdt_div_log2);
    @(posedge mclk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    file_addr = 7'h00;
    ind_ptr = 8'h00;
    pullup_enable_reg = 8'h5a;
    void'($urandom(32'h33c76f7a));
    for (int k = 0; k < 2; k++) begin
      // second pass is a reset in mid-run
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      flags = `FLAGS_RESET;
      opts = `OPTIONS_RESET;
      rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
      rd(`OFS_OPTIONS, {24'h0, opts}, 2'b00);
      check_opts();
      // every rate with both prescaler owners
      for (int i = 0; i < 16; i++) begin
        r = $urandom;
        pullup_enable_reg <= r[15:8];
        opts = {r[7:4], i[3:0]};
        bus(1'b1, `OFS_OPTIONS, opts, 4'h1);
        rd(`OFS_OPTIONS, {24'h0, opts}, 2'b00);
        check_opts();
      end
    end
    // lane 0 off and an unmapped place leave everything alone
    bus(1'b1, `OFS_OPTIONS, ~opts, 4'he);
    bus(1'b1, 4'h2, 8'h55, 4'hf);
    bus(1'b1, `OFS_FLAGS, ~flags, 4'he);
    rd(4'h2, 32'h0, 2'b10);
    rd(`OFS_OPTIONS, {24'h0, opts}, 2'b00);
    rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    // bank selects; writes to the hardware-only flags are dropped
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      file_addr <= r[6:0];
      ind_ptr <= r[15:8];
      flags = {i[2:0], flags[4:3], r[18:16]};
      bus(1'b1, `OFS_FLAGS, {i[2:0], ~flags[4:3], r[18:16]}, 4'h1);
      rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
      @(negedge mclk);
      check_port("direct_addr", {flags[6:5], file_addr}, direct_addr);
      check_port("indirect_addr", {flags[7], ind_ptr}, indirect_addr);
      @(posedge mclk);
    end
    // timeout, kick, sleep, timeout, kick beating timeout
    for (int i = 0; i < 5; i++) begin
      req = '0;
      req[2:0] = 3'(15'b101_001_010_100_001 >> (3 * i));
      if (req.wdt_timeout) flags[4] = 1'b0;
      if (req.sleep) flags[4:3] = 2'b10;
      if (req.kick) flags[4:3] = 2'b11;
      core.issue(req, OP_NONE, 8'h00, 8'h00);
      rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    end
    req = '0;
    req.file_clear = 1'b1;
    core.issue(req, OP_NONE, 8'h00, 8'h00);
    flags = {3'b000, flags[4:3], 1'b1, flags[1:0]};
    rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    // a write through the command place sets bank and alu flags, reset-cause bits kept
    bus(1'b1, `OFS_CORE_CMD, 8'hbe, 4'h1);
    flags = {3'b101, flags[4:3], 3'b110};
    rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    // add, subtract and rotates, half of them writing the flags at once
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      a = r[7:0];
      b = (i % 6 == 5) ? a : r[15:8];
      case (i % 4)
        0: begin
          op = OP_ADD;
          s = {1'b0, a} + {1'b0, b};
          res = s[7:0];
          c = s[8];
          dc = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        end
        1: begin
          op = OP_SUB;
          res = a - b;
          c = a >= b;
          dc = a[3:0] >= b[3:0];
        end
        2: begin
          op = OP_ROT_L;
          res = {a[6:0], flags[0]};
          c = a[7];
          dc = flags[1];
        end
        default: begin
          op = OP_ROT_R;
          res = {flags[0], a[7:1]};
          c = a[0];
          dc = flags[1];
        end
      endcase
      req = '0;
      req.flag_upd = 1'b1;
      req.wr_en = i[2];
      req.wr_data = r[23:16];
      core.issue(req, op, a, b);
      flags = {i[2] ? r[23:21] : flags[7:5], flags[4:3], res == 8'h00, dc, c};
      @(negedge mclk);
      check_port("alu_result", res, alu_result);
      rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
      if (i == 20) rd(`OFS_ALU_RES, {21'h0, c, dc, res == 8'h00, res}, 2'b00);
    end
    // logic result of zero raises only the zero flag
    req = '0;
    req.flag_upd = 1'b1;
    core.issue(req, OP_LOGIC, 8'h00, 8'h00);
    flags[2] = 1'b1;
    rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    // plain move: zero follows the moved value, nibble and carry kept
    r = $urandom;
    core.issue(req, OP_MOVE, r[7:0], 8'h00);
    flags[2] = (r[7:0] == 8'h00);
    rd(`OFS_FLAGS, {24'h0, flags}, 2'b00);
    repeat (2) @(posedge mclk);
    if (exp_q.size() != 0) n_errors++;
    final_report();
  end
endmodule
